/* File: logic/error_history_log.sv */
// Error history log: last stop cause plus a ten-entry error history.
// Assumes a single-cycle parameter access port and an error event port.
// Overview of operation
// [RL1] Stop cause output shows last stop error number, zero when no error.
// [RL2] Each error event appends an entry with code and status information; events during a clear are not recorded.
// [RL3] Errors following an unacknowledged one are not recorded.
// [RL4] History holds ten entries, oldest at position one.
// [RL5] History array is not cleared by reset, modelling retained storage.
// [RL6] Writing one to the clear parameter starts deleting all entries.
// [RL7] Clear parameter reads nonzero while deleting, zero when done.
// [RL8] Writing one to rewind moves the read pointer to the oldest entry.
// [RL9] Master rewinds before reading the first entry, reading in sequence.
// [RL10] The read pointer advances after each entry read.
// [RL11] A pointer at an empty position returns error code zero.
// [RL12] Master reads the error code before other entry fields.
// [RL13] Error code read copies the whole entry into a holding buffer.
// [RL14] Error code read advances the read pointer.
// [RL15] Error code is a 16-bit read-only value.
// [RL16] Severity 0 warning, 1 quick stop state 7, 2 states 8 or 9.
// [RL17] Severity 3 fatal acknowledgeable, 4 fatal not acknowledgeable.
// [RL18] Timestamp is seconds from the hours counter, capped at 536870911.
// [RL19] Each entry carries a 16-bit error-dependent qualifier.
// [RL20] When full, a new error drops the oldest entry.
// [RL21] Severity, time and qualifier reads leave the pointer alone.
`timescale 1ns/1ns
`default_nettype none

module error_history_log #(
  parameter int DEPTH = error_history_pkg::HIST_DEPTH
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Error events from monitoring
  input  wire logic        err_valid,
  input  wire logic [15:0] err_code,
  input  wire logic [2:0]  err_severity,
  input  wire logic [15:0] err_qualifier,
  input  wire logic        err_acknowledge,
  // Operating hours counter in seconds
  input  wire logic [31:0] op_seconds,
  // Parameter access
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [15:0] par_addr,
  input  wire logic [31:0] par_wdata,
  output logic      [31:0] par_rdata,
  output logic             par_rvalid,
  // Stop cause
  output logic      [15:0] last_stop_cause
);

  localparam int PW = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [15:0] code_mem [DEPTH];
  logic [2:0]  sev_mem  [DEPTH];
  logic [31:0] time_mem [DEPTH];
  logic [15:0] qual_mem [DEPTH];
  logic [PW-1:0] count_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW-1:0] clr_idx_r;
  logic          fault_active_r;
  error_history_pkg::clear_state_t clr_state_r;
  logic [15:0] hold_code_r;
  logic [2:0]  hold_sev_r;
  logic [31:0] hold_time_r;
  logic [15:0] hold_qual_r;

  // ----------------------------------------------------------------------
  // Address match
  // ----------------------------------------------------------------------
  function automatic logic sel(input logic [15:0] a, input logic [15:0] b);
    sel = (a == b);
  endfunction : sel

  // ----------------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------------
  logic wr_clear;
  logic wr_rewind;
  logic rd_code;
  logic log_event;
  logic [31:0] time_capped;
  logic        clr_busy;
  logic        hist_full;
  logic        entry_present;
  logic [31:0] rdata_nxt;
  assign wr_clear  = par_wr && sel(par_addr, error_history_pkg::ADDR_LOG_CLEAR)
                     && par_wdata[15:0] == error_history_pkg::CMD_ONE;
  assign wr_rewind = par_wr && sel(par_addr, error_history_pkg::ADDR_PTR_REWIND)
                     && par_wdata[15:0] == error_history_pkg::CMD_ONE;
  assign rd_code   = par_rd && sel(par_addr, error_history_pkg::ADDR_ENTRY_CODE);
  assign log_event = err_valid && !fault_active_r
                     && clr_state_r == error_history_pkg::CLR_IDLE; // RL3
  assign time_capped = (op_seconds > error_history_pkg::TIME_MAX) ?
                       error_history_pkg::TIME_MAX : op_seconds; // RL18

  assign clr_busy      = (clr_state_r == error_history_pkg::CLR_BUSY);
  assign hist_full     = (count_r == PW'(DEPTH));
  assign entry_present = (rd_ptr_r < count_r);

  // ----------------------------------------------------------------------
  // Fault flag for consequential-error suppression
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_active_r <= 1'b0;
    end else if (log_event) begin
      fault_active_r <= 1'b1; // RL3
    end else if (err_acknowledge) begin
      fault_active_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Stop cause
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      last_stop_cause <= error_history_pkg::NO_ERROR;
    end else if (log_event) begin
      last_stop_cause <= err_code; // RL1
    end else if (err_acknowledge) begin
      last_stop_cause <= error_history_pkg::NO_ERROR; // RL1
    end
  end

  // ----------------------------------------------------------------------
  // Entry array, not reset so contents persist
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (log_event) begin
      if (hist_full) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          code_mem[i] <= code_mem[i+1]; // RL20
        end
        code_mem[DEPTH-1] <= err_code; // RL2 RL4
      end else begin
        code_mem[count_r] <= err_code; // RL2 RL4
      end
    end else if (clr_busy) begin
      code_mem[clr_idx_r] <= error_history_pkg::NO_ERROR; // RL6
    end
  end

  always_ff @(posedge clk) begin
    if (log_event) begin
      if (hist_full) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          sev_mem[i] <= sev_mem[i+1];
        end
        sev_mem[DEPTH-1] <= err_severity; // RL16 RL17
      end else begin
        sev_mem[count_r] <= err_severity;
      end
    end else if (clr_busy) begin
      sev_mem[clr_idx_r] <= error_history_pkg::SEV_WARNING;
    end
  end

  always_ff @(posedge clk) begin
    if (log_event) begin
      if (hist_full) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          time_mem[i] <= time_mem[i+1];
        end
        time_mem[DEPTH-1] <= time_capped;
      end else begin
        time_mem[count_r] <= time_capped;
      end
    end else if (clr_busy) begin
      time_mem[clr_idx_r] <= 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (log_event) begin
      if (hist_full) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          qual_mem[i] <= qual_mem[i+1];
        end
        qual_mem[DEPTH-1] <= err_qualifier; // RL19
      end else begin
        qual_mem[count_r] <= err_qualifier;
      end
    end else if (clr_busy) begin
      qual_mem[clr_idx_r] <= 16'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Fill count; zeroed by the first reset only, then kept on reset because entries are retained
  // ----------------------------------------------------------------------
  logic count_known_r;
  always_ff @(posedge clk) begin
    if (srst && !count_known_r) begin
      count_r       <= '0; // RL5
      count_known_r <= 1'b1;
    end else if (clr_state_r == error_history_pkg::CLR_BUSY) begin
      count_r       <= '0; // RL6
      count_known_r <= 1'b1;
    end else if (log_event && count_r != PW'(DEPTH)) begin
      count_r       <= count_r + PW'(1); // RL4
    end
  end

  // ----------------------------------------------------------------------
  // Clear sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      clr_state_r <= error_history_pkg::CLR_IDLE;
      clr_idx_r   <= '0;
    end else begin
      case (clr_state_r)
        error_history_pkg::CLR_IDLE: begin
          clr_idx_r <= '0;
          if (wr_clear) begin
            clr_state_r <= error_history_pkg::CLR_BUSY; // RL6
          end
        end
        error_history_pkg::CLR_BUSY: begin
          if (clr_idx_r == PW'(DEPTH - 1)) begin
            clr_state_r <= error_history_pkg::CLR_IDLE; // RL7
          end else begin
            clr_idx_r <= clr_idx_r + PW'(1);
          end
        end
        default: clr_state_r <= error_history_pkg::CLR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read pointer, zeroed by reset, rewind or clear
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_ptr_r <= '0;
    end else if (wr_rewind || clr_state_r == error_history_pkg::CLR_BUSY) begin
      rd_ptr_r <= '0; // RL8
    end else if (rd_code && rd_ptr_r != PW'(DEPTH)) begin
      rd_ptr_r <= rd_ptr_r + PW'(1); // RL10 RL14
    end
  end

  // ----------------------------------------------------------------------
  // Holding buffer, cleared by reset and otherwise loaded only by an error code read
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_code_r <= error_history_pkg::NO_ERROR;
    end else if (rd_code && entry_present) begin
      hold_code_r <= code_mem[rd_ptr_r]; // RL13
    end else if (rd_code) begin
      hold_code_r <= error_history_pkg::NO_ERROR; // RL11
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_sev_r <= error_history_pkg::SEV_WARNING;
    end else if (rd_code && entry_present) begin
      hold_sev_r <= sev_mem[rd_ptr_r]; // RL13
    end else if (rd_code) begin
      hold_sev_r <= error_history_pkg::SEV_WARNING;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_time_r <= 32'h0;
    end else if (rd_code && entry_present) begin
      hold_time_r <= time_mem[rd_ptr_r]; // RL13
    end else if (rd_code) begin
      hold_time_r <= 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_qual_r <= 16'h0;
    end else if (rd_code && entry_present) begin
      hold_qual_r <= qual_mem[rd_ptr_r]; // RL13
    end else if (rd_code) begin
      hold_qual_r <= 16'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Read data; code comes straight from the array, one cycle after the read
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0;
    if (par_rd) begin
      case (par_addr)
        error_history_pkg::ADDR_LOG_CLEAR: begin
          rdata_nxt = {31'h0, clr_busy}; // RL7
        end
        error_history_pkg::ADDR_ENTRY_CODE: begin
          rdata_nxt = {16'h0, entry_present ? code_mem[rd_ptr_r] : 16'h0}; // RL11 RL15
        end
        error_history_pkg::ADDR_ENTRY_SEVERITY: begin
          rdata_nxt = {29'h0, hold_sev_r}; // RL21
        end
        error_history_pkg::ADDR_ENTRY_TIME: begin
          rdata_nxt = hold_time_r; // RL21
        end
        error_history_pkg::ADDR_ENTRY_QUAL: begin
          rdata_nxt = {16'h0, hold_qual_r}; // RL21
        end
        default: begin
          rdata_nxt = 32'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registered answer, one cycle after the read strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      par_rdata  <= 32'h0;
      par_rvalid <= 1'b0;
    end else begin
      par_rdata  <= rdata_nxt;
      par_rvalid <= par_rd;
    end
  end

endmodule : error_history_log

`default_nettype wire

/* File: logic/error_history_pkg.sv */
// Package for the error history log: parameter addresses, widths, codes.
// Assumes a parameter access port driven by a fieldbus front end.
package error_history_pkg;

  // ----------------------------------------------------------------------
  // Parameter addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_LOG_CLEAR      = 16'h3b08;
  localparam logic [15:0] ADDR_PTR_REWIND     = 16'h3b0a;
  localparam logic [15:0] ADDR_ENTRY_CODE     = 16'h3c02;
  localparam logic [15:0] ADDR_ENTRY_SEVERITY = 16'h3c04;
  localparam logic [15:0] ADDR_ENTRY_TIME     = 16'h3c06;
  localparam logic [15:0] ADDR_ENTRY_QUAL     = 16'h3c08;

  // ----------------------------------------------------------------------
  // Sizes, commands and limits
  // ----------------------------------------------------------------------
  localparam int          HIST_DEPTH   = 10;
  localparam logic [15:0] CMD_ONE      = 16'h0001;
  localparam logic [15:0] NO_ERROR     = 16'h0000;
  localparam logic [31:0] TIME_MAX     = 32'h1fffffff;
  localparam logic [2:0]  SEV_WARNING  = 3'h0;
  localparam logic [2:0]  SEV_QSTOP7   = 3'h1;
  localparam logic [2:0]  SEV_QSTOP89  = 3'h2;
  localparam logic [2:0]  SEV_FATAL_ACK   = 3'h3;
  localparam logic [2:0]  SEV_FATAL_NOACK = 3'h4;

  typedef enum logic [1:0] {
    CLR_IDLE = 2'b01,
    CLR_BUSY = 2'b10
  } clear_state_t;

endpackage : error_history_pkg

/* File: tb/error_history_log_bench.sv */
// Self-checking bench for the error history log.
// Events driven directly; parameters go through the fieldbus master model.
`timescale 1ns/1ns
`default_nettype none
module error_history_log_bench;
  typedef struct packed {logic [15:0] c; logic [2:0] s; logic [15:0] q; logic [31:0] t;} entry_t;
  logic        clk, srst, err_valid, err_acknowledge, par_wr, par_rd, par_rvalid;
  logic [2:0]  err_severity;
  logic [15:0] err_code, err_qualifier, par_addr, last_stop_cause;
  logic [31:0] op_seconds, par_wdata, par_rdata, c, s, t, q;
  entry_t      e;
  entry_t      hist[$];
  int          seed = 17910, fails = 0, samples_checked = 0, cycles = 0;
  error_history_log u_dut (.clk(clk), .srst(srst), .err_valid(err_valid), .err_code(err_code),
    .err_severity(err_severity), .err_qualifier(err_qualifier),
    .err_acknowledge(err_acknowledge), .op_seconds(op_seconds), .par_wr(par_wr),
    .par_rd(par_rd), .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
    .par_rvalid(par_rvalid), .last_stop_cause(last_stop_cause));
  fieldbus_master u_master (.clk(clk), .par_rdata(par_rdata), .par_rvalid(par_rvalid),
    .par_wr(par_wr), .par_rd(par_rd), .par_addr(par_addr), .par_wdata(par_wdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] cap(input logic [31:0] v);
    return (v > error_history_pkg::TIME_MAX) ? error_history_pkg::TIME_MAX : v;
  endfunction : cap
  function automatic void add(input entry_t n);
    hist.push_back(n);
    if (hist.size() > error_history_pkg::HIST_DEPTH) hist.pop_front();
  endfunction : add
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic end_sim;
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic ev(input entry_t n);
    {err_code, err_severity, err_qualifier, op_seconds} = n;
    err_valid = 1'b1;
    @(posedge clk);
    #1;
    err_valid = 1'b0;
  endtask : ev
  task automatic ack;
    err_acknowledge = 1'b1;
    @(posedge clk);
    #1;
    err_acknowledge = 1'b0;
    @(posedge clk);
    #1;
  endtask : ack
  task automatic read_all;
    u_master.rewind();
    foreach (hist[k]) begin
      u_master.entry(c, s, t, q);
      cmp(c, {16'h0, hist[k].c});
      cmp(s, {29'h0, hist[k].s});
      cmp(t, cap(hist[k].t));
      cmp(q, {16'h0, hist[k].q});
    end
    u_master.entry(c, s, t, q);
    cmp(c, 32'h0);
  endtask : read_all
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    {err_valid, err_acknowledge, err_severity, err_code, err_qualifier, op_seconds} = '0;
    srst = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    cmp({16'h0, last_stop_cause}, 32'h0);
    u_master.clear_log(s, t);
    cmp(s, 32'h1);
    cmp(t, 32'h0);
    read_all();
    u_master.wr(error_history_pkg::ADDR_LOG_CLEAR, 32'h2);
    u_master.rd(error_history_pkg::ADDR_LOG_CLEAR, c);
    cmp(c, 32'h0);
    for (int i = 0; i < 13; i++) begin
      e.c = 16'($random(seed)) | 16'h1;
      e.s = 3'(i % 5);
      e.q = 16'($random(seed));
      e.t = (i % 2) ? $random(seed) : 32'($random(seed)) >> 3;
      ev(e);
      add(e);
      if (i == 6) begin
        e.c = e.c + 16'h2;
        ev(e);
      end
      @(posedge clk);
      #1;
      cmp({16'h0, last_stop_cause}, {16'h0, hist[$].c});
      ack();
      cmp({16'h0, last_stop_cause}, 32'h0);
    end
    read_all();
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    read_all();
    end_sim();
  end
endmodule : error_history_log_bench
`default_nettype wire

/* File: tb/error_history_log_properties.sv */
// Checker for the error history log parameter port and stop cause.
// Bound to every error_history_log instance; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module error_history_log_properties #(
  parameter int DEPTH = 10
) (
  // Clock, reset and events
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        err_valid,
  input wire logic [15:0] err_code,
  input wire logic        err_acknowledge,
  // Parameter port and stop cause
  input wire logic        par_wr,
  input wire logic        par_rd,
  input wire logic [15:0] par_addr,
  input wire logic [31:0] par_wdata,
  input wire logic [31:0] par_rdata,
  input wire logic        par_rvalid,
  input wire logic [15:0] last_stop_cause
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  int   clr_cnt;
  logic clr_cmd;
  assign clr_cmd = par_wr && par_addr == error_history_pkg::ADDR_LOG_CLEAR
                   && par_wdata[15:0] == error_history_pkg::CMD_ONE;
  // Cycles of deletion still to run
  always_ff @(posedge clk) begin
    if (srst) clr_cnt <= 0;
    else if (clr_cmd) clr_cnt <= DEPTH;
    else if (clr_cnt != 0) clr_cnt <= clr_cnt - 1;
  end
  sequence s_rd(a);
    par_rd && par_addr == a;
  endsequence
  chk_read_answer:
    assert property (par_rd |=> par_rvalid) else $error("read not answered");
  chk_answer_cause:
    assert property (par_rvalid |-> $past(par_rd)) else $error("answer without read");
  chk_code_width:
    assert property (s_rd(error_history_pkg::ADDR_ENTRY_CODE) |=> par_rdata[31:16] == 16'h0)
      else $error("code wider than 16 bits");
  chk_event_cause:
    assert property (err_valid && !err_acknowledge && last_stop_cause == 16'h0
      && clr_cnt == 0 && !clr_cmd |=> last_stop_cause == $past(err_code))
      else $error("event not shown as stop cause");
  chk_ack_clears:
    assert property (err_acknowledge && !err_valid |=> last_stop_cause == 16'h0)
      else $error("stop cause kept after acknowledge");
  chk_cause_hold:
    assert property (last_stop_cause != 16'h0 && !err_acknowledge |=> $stable(last_stop_cause))
      else $error("stop cause overwritten");
  chk_clear_busy:
    assert property (s_rd(error_history_pkg::ADDR_LOG_CLEAR) ##0 clr_cnt != 0
      |=> par_rdata == 32'h1) else $error("clear not busy");
  chk_clear_done:
    assert property (s_rd(error_history_pkg::ADDR_LOG_CLEAR) ##0 clr_cnt == 0
      |=> par_rdata == 32'h0) else $error("clear not finished");
  chk_severity_range:
    assert property (s_rd(error_history_pkg::ADDR_ENTRY_SEVERITY) |=> par_rdata <= 32'h4)
      else $error("severity out of range");
  chk_time_cap:
    assert property (s_rd(error_history_pkg::ADDR_ENTRY_TIME)
      |=> par_rdata <= error_history_pkg::TIME_MAX) else $error("timestamp above cap");
endmodule : error_history_log_properties
bind error_history_log error_history_log_properties #(.DEPTH(DEPTH)) u_props (
  .clk(clk), .srst(srst), .err_valid(err_valid), .err_code(err_code),
  .err_acknowledge(err_acknowledge), .par_wr(par_wr), .par_rd(par_rd),
  .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
  .par_rvalid(par_rvalid), .last_stop_cause(last_stop_cause));
`default_nettype wire

/* File: tb/fieldbus_master.sv */
// Fieldbus master model issuing parameter reads and writes.
// Expects one-cycle strobes and a registered answer one cycle later.
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master (
  // Clock and answer
  input  wire logic        clk,
  input  wire logic [31:0] par_rdata,
  input  wire logic        par_rvalid,
  // Requests
  output var  logic        par_wr,
  output var  logic        par_rd,
  output var  logic [15:0] par_addr,
  output var  logic [31:0] par_wdata
);
  initial {par_wr, par_rd, par_addr, par_wdata} = '0;
  // Released address and data are inverted so stale values never match
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    par_addr = a;
    par_wdata = d;
    par_wr = 1'b1;
    @(posedge clk);
    #1;
    par_wr = 1'b0;
    par_addr = ~a;
    par_wdata = ~d;
    @(posedge clk);
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    par_addr = a;
    par_rd = 1'b1;
    @(posedge clk);
    #1;
    d = par_rvalid ? par_rdata : 32'hdead_beef;
    par_rd = 1'b0;
    par_addr = ~a;
    @(posedge clk);
    #1;
  endtask : rd
  task automatic rewind;
    wr(error_history_pkg::ADDR_PTR_REWIND, 32'h1);
  endtask : rewind
  task automatic entry(output logic [31:0] c, s, t, q);
    rd(error_history_pkg::ADDR_ENTRY_CODE, c);
    rd(error_history_pkg::ADDR_ENTRY_SEVERITY, s);
    rd(error_history_pkg::ADDR_ENTRY_TIME, t);
    rd(error_history_pkg::ADDR_ENTRY_QUAL, q);
  endtask : entry
  task automatic clear_log(output logic [31:0] busy, done);
    wr(error_history_pkg::ADDR_LOG_CLEAR, 32'h1);
    rd(error_history_pkg::ADDR_LOG_CLEAR, busy);
    done = busy;
    for (int i = 0; i < 30 && done != 32'h0; i++) rd(error_history_pkg::ADDR_LOG_CLEAR, done);
  endtask : clear_log
endmodule : fieldbus_master
`default_nettype wire
